// file: rtl/ptp_pkg.sv
// Constants and types of the programmable timing pulse output block.
// Assumes a single 20 MHz clock taken from the disciplined system oscillator.
package ptp_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned PW_DEFAULT_US = 1000;
    localparam int unsigned PW_DEFAULT_CYC = (PW_DEFAULT_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned RATE_MAX_PPS = 10000000;
    localparam int unsigned RATE_MIN_PPS = 1;
    // Manufacturing choice of the fixed-rate output
    localparam int unsigned FIXED_RATE_PPS = 10000000;

    localparam int CNT_W = 25;
    localparam int ACC_W = 26;
    localparam int RATE_W = 24;
    localparam int SEL_W = 3;

    localparam logic [CNT_W-1:0] SEC_CYC = CNT_W'(CLK_HZ);

    // ****************************************************************
    // Register map, byte offsets
    // ****************************************************************
    localparam logic [4:0] REG_CTRL_OFS = 5'h00;
    localparam logic [4:0] REG_RATE_OFS = 5'h04;
    localparam logic [4:0] REG_SYNTHESIZED_RATE_SEL_OFS = 5'h08;
    localparam logic [4:0] REG_PW_OFS = 5'h0C;
    localparam logic [4:0] REG_STATUS_OFS = 5'h10;
    localparam logic [4:0] REG_MASK_OFS = 5'h14;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int CTRL_SEL_LSB = 0;
    localparam int STAT_EV_SEC_BIT = 0;
    localparam int STAT_EV_CFG_BIT = 1;
    localparam int STAT_EV_ALM_BIT = 2;
    localparam int STAT_ALARM_BIT = 3;
    localparam int STAT_MODE_LSB = 4;
    localparam int EV_W = 3;

    localparam logic [SEL_W-1:0] SEL_RATE = 3'h0;
    localparam logic [SEL_W-1:0] SEL_PPM = 3'h1;
    localparam logic [SEL_W-1:0] SEL_EVEN = 3'h2;
    localparam logic [SEL_W-1:0] SEL_RISE = 3'h3;
    localparam logic [SEL_W-1:0] SEL_FALL = 3'h4;
    localparam logic [SEL_W-1:0] SEL_SYNTHESIZED_RATE_SEL = 3'h5;

    localparam logic [SEL_W-1:0] CTRL_RST = SEL_RISE;
    localparam logic [RATE_W-1:0] RATE_RST = 24'h000001;
    localparam logic [RATE_W-1:0] SYNTHESIZED_RATE_SEL_RST = 24'h000001;
    localparam logic [CNT_W-1:0] PW_RST = CNT_W'(PW_DEFAULT_CYC);
    localparam logic [EV_W-1:0] MASK_RST = 3'h0;

    // ****************************************************************
    // Output selections, one-hot
    // ****************************************************************
    typedef enum logic [5:0] {
        PTP_MODE_RATE  = 6'h01,
        PTP_MODE_PPM   = 6'h02,
        PTP_MODE_EVEN  = 6'h04,
        PTP_MODE_RISE  = 6'h08,
        PTP_MODE_FALL  = 6'h10,
        PTP_MODE_SYNTHESIZED_RATE_SEL = 6'h20
    } ptp_mode_e;

endpackage

// file: rtl/ptp_rate_gen.sv
// Phase accumulator that turns a pulses-per-second figure into a square wave.
// Assumes the clock is the disciplined oscillator at CLK_HZ; rate up to CLK_HZ/2.
`timescale 1ns/10ps
module ptp_rate_gen
    import ptp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clr_i,
    input wire logic [RATE_W-1:0] rate_i,
    output logic wave_o
);

    // ****************************************************************
    // Accumulator
    // ****************************************************************
    logic [ACC_W-1:0] acc_r;
    logic [ACC_W-1:0] sum;
    logic wrap;

    // Two half periods per pulse; whole seconds sum exactly to CLK_HZ, so no drift
    assign sum = acc_r + ACC_W'({rate_i, 1'b0});
    assign wrap = (sum >= ACC_W'(CLK_HZ));

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            acc_r <= '0;
            wave_o <= 1'b0;
        end else if (clr_i) begin
            acc_r <= '0;
            wave_o <= 1'b1;
        end else if (wrap) begin
            acc_r <= sum - ACC_W'(CLK_HZ);
            wave_o <= ~wave_o;
        end else begin
            acc_r <= sum;
        end
    end

endmodule // ptp_rate_gen

// file: rtl/ptp_timing_out.sv
// Programmable timing pulse output: selectable pulse trains, synthesizer,
// fixed-rate output, differential second pulse and alarm, behind Avalon-MM.
// Assumes SEC_TICK_I, MIN_TICK_I and SEC_EVEN_I come from system time on CLK_I.
`timescale 1ns/10ps

module ptp_timing_out
    import ptp_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic [4:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    output logic IRQ_O,
    input wire logic SEC_TICK_I,
    input wire logic MIN_TICK_I,
    input wire logic SEC_EVEN_I,
    input wire logic LOCK_LOST_I,
    input wire logic HW_FAULT_I,
    output logic PROG_O,
    output logic FIXED_O,
    output logic DIFF_P_O,
    output logic DIFF_N_O,
    input wire logic ALARM_I,
    output logic ALARM_O,
    output logic ALARM_OE_N_O
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic ack_r;
    logic rd_acc;
    logic wr_acc;
    logic [31:0] wmask;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [31:0] wr_ctrl;
    logic [31:0] wr_rate;
    logic [31:0] wr_synthesized_rate_sel;
    logic [31:0] wr_pw;
    logic [SEL_W-1:0] sel_r;
    logic [RATE_W-1:0] rate_r;
    logic [RATE_W-1:0] synthesized_rate_sel_r;
    logic [CNT_W-1:0] pw_r;
    logic [EV_W-1:0] mask_r;
    logic [EV_W-1:0] ev_r;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    logic cfg_dirty_r;
    logic [SEL_W-1:0] act_sel_r;
    logic [RATE_W-1:0] act_rate_r;
    logic [RATE_W-1:0] act_synthesized_rate_sel_r;
    logic [CNT_W-1:0] act_pw_r;
    logic [SEL_W-1:0] sel_now;
    logic [RATE_W-1:0] rate_now;
    logic [RATE_W-1:0] synthesized_rate_sel_now;
    logic [CNT_W-1:0] pw_now;
    ptp_mode_e mode_now;
    logic [CNT_W-1:0] sec_cnt_r;
    logic [CNT_W-1:0] sec_cnt_nxt;
    logic seen_r;
    logic min_r;
    logic even_r;
    logic rise_win;
    logic fall_win;
    logic wave_aligned;
    logic wave_synthesized_rate_sel;
    logic prog_nxt;
    logic [1:0] lock_sync_r;
    logic [1:0] fault_sync_r;
    logic [1:0] pin_sync_r;
    logic alarm_r;

    // ****************************************************************
    // Avalon-MM slave, one wait state per access
    // ****************************************************************
    // Fixed latency keeps read data registered and the decode off the bus path
    assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_r;
    assign rd_acc = AVS_READ_I & ack_r;
    assign wr_acc = AVS_WRITE_I & ack_r;
    assign AVS_READDATA_O = rdata_r;
    assign wmask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                    {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
    assign wr_ctrl = (AVS_WRITEDATA_I & wmask) | (32'(sel_r) & ~wmask);
    assign wr_rate = (AVS_WRITEDATA_I & wmask) | (32'(rate_r) & ~wmask);
    assign wr_synthesized_rate_sel = (AVS_WRITEDATA_I & wmask) | (32'(synthesized_rate_sel_r) & ~wmask);
    assign wr_pw = (AVS_WRITEDATA_I & wmask) | (32'(pw_r) & ~wmask);

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (AVS_READ_I | AVS_WRITE_I) & ~ack_r;
        end
    end

    always_comb begin
        rdata_nxt = 32'h00000000;
        if (AVS_ADDRESS_I == REG_CTRL_OFS) begin
            rdata_nxt = 32'(sel_r);
        end else if (AVS_ADDRESS_I == REG_RATE_OFS) begin
            rdata_nxt = 32'(rate_r);
        end else if (AVS_ADDRESS_I == REG_SYNTHESIZED_RATE_SEL_OFS) begin
            rdata_nxt = 32'(synthesized_rate_sel_r);
        end else if (AVS_ADDRESS_I == REG_PW_OFS) begin
            rdata_nxt = 32'(pw_r);
        end else if (AVS_ADDRESS_I == REG_STATUS_OFS) begin
            rdata_nxt[EV_W-1:0] = ev_r;
            rdata_nxt[STAT_ALARM_BIT] = pin_sync_r[1];
            rdata_nxt[STAT_MODE_LSB +: SEL_W] = act_sel_r;
        end else if (AVS_ADDRESS_I == REG_MASK_OFS) begin
            rdata_nxt = 32'(mask_r);
        end
    end

    // Data captured in the wait cycle and held through the accepting edge
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            rdata_r <= 32'h00000000;
        end else if (AVS_READ_I & ~ack_r) begin
            rdata_r <= rdata_nxt;
        end
    end

    // ****************************************************************
    // Configuration storage written by software
    // ****************************************************************
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            sel_r <= CTRL_RST;
            rate_r <= RATE_RST;
            synthesized_rate_sel_r <= SYNTHESIZED_RATE_SEL_RST;
            pw_r <= PW_RST;
            mask_r <= MASK_RST;
        end else if (wr_acc) begin
            if (AVS_ADDRESS_I == REG_CTRL_OFS) begin
                // Codes without a selection are ignored
                if (wr_ctrl[CTRL_SEL_LSB +: SEL_W] <= SEL_SYNTHESIZED_RATE_SEL) begin
                    sel_r <= wr_ctrl[CTRL_SEL_LSB +: SEL_W];
                end
            end else if (AVS_ADDRESS_I == REG_RATE_OFS) begin
                if (wr_rate >= RATE_MIN_PPS && wr_rate <= RATE_MAX_PPS) begin
                    rate_r <= wr_rate[RATE_W-1:0];
                end
            end else if (AVS_ADDRESS_I == REG_SYNTHESIZED_RATE_SEL_OFS) begin
                if (wr_synthesized_rate_sel >= RATE_MIN_PPS && wr_synthesized_rate_sel <= RATE_MAX_PPS) begin
                    synthesized_rate_sel_r <= wr_synthesized_rate_sel[RATE_W-1:0];
                end
            end else if (AVS_ADDRESS_I == REG_PW_OFS) begin
                if (wr_pw != 32'h00000000 && wr_pw < CLK_HZ) begin
                    pw_r <= wr_pw[CNT_W-1:0];
                end
            end else if (AVS_ADDRESS_I == REG_MASK_OFS) begin
                mask_r <= (AVS_WRITEDATA_I[EV_W-1:0] & wmask[EV_W-1:0])
                          | (mask_r & ~wmask[EV_W-1:0]);
            end
        end
    end

    // ****************************************************************
    // Second-boundary hand-over of the active configuration
    // ****************************************************************
    // Swapping only on the boundary, where every aligned train restarts, avoids runts
    assign sel_now = SEC_TICK_I ? sel_r : act_sel_r;
    assign rate_now = SEC_TICK_I ? rate_r : act_rate_r;
    assign synthesized_rate_sel_now = SEC_TICK_I ? synthesized_rate_sel_r : act_synthesized_rate_sel_r;
    assign pw_now = SEC_TICK_I ? pw_r : act_pw_r;

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            act_sel_r <= CTRL_RST;
            act_rate_r <= RATE_RST;
            act_synthesized_rate_sel_r <= SYNTHESIZED_RATE_SEL_RST;
            act_pw_r <= PW_RST;
        end else if (SEC_TICK_I) begin
            act_sel_r <= sel_r;
            act_rate_r <= rate_r;
            act_synthesized_rate_sel_r <= synthesized_rate_sel_r;
            act_pw_r <= pw_r;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            cfg_dirty_r <= 1'b0;
        end else if (wr_acc && AVS_ADDRESS_I <= REG_PW_OFS) begin
            cfg_dirty_r <= 1'b1;
        end else if (SEC_TICK_I) begin
            cfg_dirty_r <= 1'b0;
        end
    end

    always_comb begin
        case (sel_now)
            SEL_RATE: mode_now = PTP_MODE_RATE;
            SEL_PPM: mode_now = PTP_MODE_PPM;
            SEL_EVEN: mode_now = PTP_MODE_EVEN;
            SEL_FALL: mode_now = PTP_MODE_FALL;
            SEL_SYNTHESIZED_RATE_SEL: mode_now = PTP_MODE_SYNTHESIZED_RATE_SEL;
            default: mode_now = PTP_MODE_RISE;
        endcase
    end

    // ****************************************************************
    // Position within the second
    // ****************************************************************
    // Saturates so a missing boundary cannot fake a pulse
    always_comb begin
        if (SEC_TICK_I) begin
            sec_cnt_nxt = '0;
        end else if (sec_cnt_r < SEC_CYC) begin
            sec_cnt_nxt = sec_cnt_r + CNT_W'(1);
        end else begin
            sec_cnt_nxt = sec_cnt_r;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            sec_cnt_r <= SEC_CYC;
            seen_r <= 1'b0;
            min_r <= 1'b0;
            even_r <= 1'b0;
        end else begin
            sec_cnt_r <= sec_cnt_nxt;
            if (SEC_TICK_I) begin
                seen_r <= 1'b1;
                min_r <= MIN_TICK_I;
                even_r <= SEC_EVEN_I;
            end
        end
    end

    assign rise_win = (SEC_TICK_I | seen_r) && (sec_cnt_nxt < pw_now);
    assign fall_win = seen_r && !SEC_TICK_I && (sec_cnt_nxt >= SEC_CYC - pw_now)
                      && (sec_cnt_nxt < SEC_CYC);

    // ****************************************************************
    // Rate generators
    // ****************************************************************
    ptp_rate_gen u_aligned (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .clr_i(SEC_TICK_I),
        .rate_i(rate_now),
        .wave_o(wave_aligned)
    );

    // Runs from the disciplined clock only; never restarted by the second
    ptp_rate_gen u_synthesized_rate_sel (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .clr_i(1'b0),
        .rate_i(synthesized_rate_sel_now),
        .wave_o(wave_synthesized_rate_sel)
    );

    ptp_rate_gen u_fixed (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .clr_i(SEC_TICK_I),
        .rate_i(RATE_W'(FIXED_RATE_PPS)),
        .wave_o(FIXED_O)
    );

    // ****************************************************************
    // Programmable and differential outputs
    // ****************************************************************
    always_comb begin
        case (mode_now)
            PTP_MODE_RATE: prog_nxt = wave_aligned;
            PTP_MODE_PPM: prog_nxt = rise_win & (SEC_TICK_I ? MIN_TICK_I : min_r);
            PTP_MODE_EVEN: prog_nxt = rise_win & (SEC_TICK_I ? SEC_EVEN_I : even_r);
            PTP_MODE_RISE: prog_nxt = rise_win;
            PTP_MODE_FALL: prog_nxt = fall_win;
            PTP_MODE_SYNTHESIZED_RATE_SEL: prog_nxt = wave_synthesized_rate_sel;
            default: prog_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            PROG_O <= 1'b0;
            DIFF_P_O <= 1'b0;
            DIFF_N_O <= 1'b1;
        end else begin
            PROG_O <= prog_nxt;
            DIFF_P_O <= rise_win;
            DIFF_N_O <= ~rise_win;
        end
    end

    // ****************************************************************
    // Alarm
    // ****************************************************************
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            lock_sync_r <= 2'h0;
            fault_sync_r <= 2'h0;
            pin_sync_r <= 2'h0;
            alarm_r <= 1'b0;
        end else begin
            lock_sync_r <= {lock_sync_r[0], LOCK_LOST_I};
            fault_sync_r <= {fault_sync_r[0], HW_FAULT_I};
            pin_sync_r <= {pin_sync_r[0], ALARM_I};
            alarm_r <= lock_sync_r[1] | fault_sync_r[1];
        end
    end

    // Open collector: pull low while alarmed, release otherwise
    assign ALARM_O = 1'b0;
    assign ALARM_OE_N_O = ~alarm_r;

    // ****************************************************************
    // Events and interrupt
    // ****************************************************************
    assign ev_set[STAT_EV_SEC_BIT] = SEC_TICK_I;
    assign ev_set[STAT_EV_CFG_BIT] = SEC_TICK_I & cfg_dirty_r;
    assign ev_set[STAT_EV_ALM_BIT] = (lock_sync_r[1] | fault_sync_r[1]) & ~alarm_r;
    // Only bits the reader actually saw are cleared
    assign ev_clr = (rd_acc && AVS_ADDRESS_I == REG_STATUS_OFS) ? rdata_r[EV_W-1:0] : '0;

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ev_r <= '0;
        end else begin
            ev_r <= (ev_r & ~ev_clr) | ev_set;
        end
    end

    assign IRQ_O = |(ev_r & mask_r);

endmodule // ptp_timing_out

// file: testbench/ptp_timing_out_props.sv
// Port checker for the timing pulse output block.
// Assumes it is bound to ptp_timing_out and sees its ports only.
`timescale 1ns/10ps
module ptp_timing_out_props (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic AVS_WAITREQUEST_O,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic SEC_TICK_I,
    input wire logic LOCK_LOST_I,
    input wire logic HW_FAULT_I,
    input wire logic FIXED_O,
    input wire logic DIFF_P_O,
    input wire logic DIFF_N_O,
    input wire logic ALARM_O,
    input wire logic ALARM_OE_N_O
);
    // ****************
    // Assertions
    // ****************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    chk_wait_one: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("waitrequest held past one cycle");
    chk_read_stands: assert property (!AVS_READ_I |=> $stable(AVS_READDATA_O))
        else $error("read data moved without a read");
    chk_diff_pair: assert property (DIFF_N_O == !DIFF_P_O)
        else $error("differential pair not complementary");
    chk_diff_start: assert property (SEC_TICK_I |=> DIFF_P_O && !DIFF_N_O)
        else $error("differential pulse missed the second");
    chk_diff_cause: assert property ($rose(DIFF_P_O) |-> $past(SEC_TICK_I))
        else $error("differential pulse rose off the second");
    // Three edges: two sync stages and the output register
    chk_alarm_set: assert property ((LOCK_LOST_I || HW_FAULT_I) [*4] |-> !ALARM_OE_N_O)
        else $error("alarm not driven after fault");
    chk_alarm_free: assert property (!(LOCK_LOST_I || HW_FAULT_I) [*4] |-> ALARM_OE_N_O)
        else $error("alarm driven without fault");
    chk_alarm_pin: assert property (ALARM_O == 1'b0)
        else $error("alarm output not low");
    // Fixed rate is half the clock, so it toggles every cycle except at the second tick, which forces it high
    chk_fixed_run: assert property (SEC_TICK_I |-> ##3 (FIXED_O != $past(FIXED_O)) ##1 (FIXED_O != $past(FIXED_O)))
        else $error("fixed rate output not toggling");
endmodule // ptp_timing_out_props

bind ptp_timing_out ptp_timing_out_props chk (.CLK_I, .RST_N_I, .AVS_READ_I, .AVS_WRITE_I,
    .AVS_WAITREQUEST_O, .AVS_READDATA_O, .SEC_TICK_I, .LOCK_LOST_I, .HW_FAULT_I, .FIXED_O,
    .DIFF_P_O, .DIFF_N_O, .ALARM_O, .ALARM_OE_N_O);

// file: testbench/ptp_pulse_rx.sv
// Model of the timing equipment that receives the pulse and alarm outputs.
// Assumes one clock; counts are cleared by the bench between scenarios.
`timescale 1ns/10ps
module ptp_pulse_rx (
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic pulse_i,
    input wire logic oe_n_i,
    input wire logic drv_i,
    output logic alarm_wire_o,
    output int rise_cnt_o,
    output int hi_cnt_o
);
    logic last_r = 1'b0;
    // Pull-up holds the wire high once released
    assign alarm_wire_o = oe_n_i ? 1'b1 : drv_i;
    always_ff @(posedge clk_i) begin
        last_r <= pulse_i;
        if (clr_i) begin
            rise_cnt_o <= 0;
            hi_cnt_o <= 0;
        end else begin
            rise_cnt_o <= rise_cnt_o + int'(pulse_i && !last_r);
            hi_cnt_o <= hi_cnt_o + int'(pulse_i);
        end
    end
endmodule // ptp_pulse_rx

// file: testbench/ptp_timing_out_tb_top.sv
// Self-checking bench for the timing pulse output block.
// Assumes bench ticks stand in for system time, spaced far under a second.
`timescale 1ns/10ps
module ptp_timing_out_tb_top
    import ptp_pkg::*;
;
    logic CLK_I = 1'b0;
    logic RST_N_I = 1'b0;
    logic [4:0] AVS_ADDRESS_I = 5'h00;
    logic AVS_READ_I = 1'b0;
    logic AVS_WRITE_I = 1'b0;
    logic [31:0] AVS_WRITEDATA_I = 32'h0;
    logic [3:0] AVS_BYTEENABLE_I = 4'hF;
    logic SEC_TICK_I = 1'b0;
    logic MIN_TICK_I = 1'b0;
    logic SEC_EVEN_I = 1'b0;
    logic LOCK_LOST_I = 1'b0;
    logic HW_FAULT_I = 1'b0;
    logic clr_rx = 1'b0;
    logic [31:0] AVS_READDATA_O;
    logic AVS_WAITREQUEST_O, IRQ_O, PROG_O, FIXED_O, DIFF_P_O, DIFF_N_O, ALARM_O, ALARM_OE_N_O;
    wire alarm_wire;
    int rise_cnt, hi_cnt;
    int error_cnt = 0;
    int check_count = 0;

    always #25 CLK_I = ~CLK_I;

    ptp_timing_out dut (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
        .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
        .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
        .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .IRQ_O(IRQ_O), .SEC_TICK_I(SEC_TICK_I),
        .MIN_TICK_I(MIN_TICK_I), .SEC_EVEN_I(SEC_EVEN_I), .LOCK_LOST_I(LOCK_LOST_I),
        .HW_FAULT_I(HW_FAULT_I), .PROG_O(PROG_O), .FIXED_O(FIXED_O), .DIFF_P_O(DIFF_P_O),
        .DIFF_N_O(DIFF_N_O), .ALARM_I(alarm_wire), .ALARM_O(ALARM_O),
        .ALARM_OE_N_O(ALARM_OE_N_O));
    ptp_pulse_rx rx (.clk_i(CLK_I), .clr_i(clr_rx), .pulse_i(PROG_O), .oe_n_i(ALARM_OE_N_O),
        .drv_i(ALARM_O), .alarm_wire_o(alarm_wire), .rise_cnt_o(rise_cnt), .hi_cnt_o(hi_cnt));

    // ****************
    // Shared tasks
    // ****************
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rng(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n = 0;
        @(posedge CLK_I);
        AVS_ADDRESS_I <= a;
        AVS_WRITEDATA_I <= d;
        AVS_WRITE_I <= w;
        AVS_READ_I <= !w;
        forever begin
            @(posedge CLK_I);
            if (AVS_WAITREQUEST_O === 1'b0 || n == 20) break;
            n++;
        end
        rng(n, 0, 19);
        q = AVS_READDATA_O;
        AVS_WRITE_I <= 1'b0;
        AVS_READ_I <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_I);
        #1;
    endtask
    task automatic tick(input logic m, input logic e);
        @(posedge CLK_I);
        SEC_TICK_I <= 1'b1;
        MIN_TICK_I <= m;
        SEC_EVEN_I <= e;
        @(posedge CLK_I);
        SEC_TICK_I <= 1'b0;
        MIN_TICK_I <= 1'b0;
        SEC_EVEN_I <= 1'b0;
        #1;
    endtask
    task automatic clr;
        @(posedge CLK_I);
        clr_rx <= 1'b1;
        @(posedge CLK_I);
        clr_rx <= 1'b0;
        #1;
    endtask
    // New selection only lands at a tick, so apply with one and settle
    task automatic apply(input logic [SEL_W-1:0] sel);
        wr(REG_CTRL_OFS, 32'(sel));
        tick(1'b0, 1'b0);
        cyc(20);
        clr;
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_reset;
        logic [4:0] a [6] = '{REG_CTRL_OFS, REG_RATE_OFS, REG_SYNTHESIZED_RATE_SEL_OFS, REG_PW_OFS,
            REG_MASK_OFS, 5'h18};
        logic [31:0] e [6] = '{32'h3, 32'h1, 32'h1, 32'h4E20, 32'h0, 32'h0};
        logic [31:0] q;
        cmp(DIFF_N_O, 32'h1);
        wr(5'h18, 32'hFFFF);
        wr(REG_CTRL_OFS, 32'h6);
        foreach (a[i]) begin
            rd(a[i], q);
            cmp(q, e[i]);
        end
        $display("t_reset done");
    endtask
    task automatic t_rise;
        logic [31:0] q;
        wr(REG_PW_OFS, 32'h8);
        tick(1'b0, 1'b0);
        // The applying tick already runs the new 8-cycle width
        cyc(20010);
        rd(REG_PW_OFS, q);
        cmp(q, 32'h8);
        clr;
        tick(1'b0, 1'b0);
        cmp(PROG_O, 32'h1);
        cmp(DIFF_P_O, 32'h1);
        cyc(15);
        cmp(rise_cnt, 32'h1);
        cmp(hi_cnt, 32'h8);
        $display("t_rise done");
    endtask
    task automatic t_gate(input logic [SEL_W-1:0] sel);
        logic m;
        m = (sel == SEL_PPM);
        apply(sel);
        tick(1'b0, 1'b0);
        cyc(20);
        cmp(rise_cnt, 32'h0);
        tick(m, !m);
        cyc(20);
        cmp(rise_cnt, 32'h1);
        cmp(hi_cnt, 32'h8);
        $display("t_gate done");
    endtask
    // Width so wide that the pulse opens ten cycles into the second, so the
    // falling edge on the next boundary is seen without waiting a whole second
    task automatic t_fall;
        wr(REG_PW_OFS, 32'(SEC_CYC) - 32'hA);
        apply(SEL_FALL);
        cmp(PROG_O, 32'h1);
        tick(1'b0, 1'b0);
        cmp(PROG_O, 32'h0);
        cyc(20);
        cmp(rise_cnt, 32'h1);
        $display("t_fall done");
    endtask
    task automatic t_rate;
        logic [31:0] q;
        wr(REG_RATE_OFS, 32'h0);
        wr(REG_RATE_OFS, 32'h989681);
        rd(REG_RATE_OFS, q);
        cmp(q, 32'h1);
        wr(REG_RATE_OFS, 32'h989680);
        rd(REG_RATE_OFS, q);
        cmp(q, 32'h989680);
        wr(REG_RATE_OFS, 32'hF4240);
        wr(REG_CTRL_OFS, 32'(SEL_RATE));
        clr;
        cyc(50);
        cmp(rise_cnt, 32'h0);
        tick(1'b0, 1'b0);
        clr;
        cyc(200);
        rng(rise_cnt, 9, 11);
        $display("t_rate done");
    endtask
    task automatic t_synthesized_rate_sel;
        logic [31:0] r [2] = '{32'h1F4000, 32'h178F40};
        int e;
        foreach (r[i]) begin
            e = int'(r[i] / 32'd20000);
            wr(REG_SYNTHESIZED_RATE_SEL_OFS, r[i]);
            apply(SEL_SYNTHESIZED_RATE_SEL);
            cyc(1000);
            rng(rise_cnt, e - 1, e + 2);
        end
        $display("t_synthesized_rate_sel done");
    endtask
    task automatic t_alarm;
        logic [31:0] q;
        wr(REG_MASK_OFS, 32'h7);
        rd(REG_STATUS_OFS, q);
        tick(1'b0, 1'b0);
        cyc(2);
        cmp(IRQ_O, 32'h1);
        rd(REG_STATUS_OFS, q);
        cmp(q & 32'h1, 32'h1);
        cyc(1);
        cmp(IRQ_O, 32'h0);
        LOCK_LOST_I <= 1'b1;
        cyc(6);
        cmp(ALARM_OE_N_O, 32'h0);
        cmp(alarm_wire, 32'h0);
        cmp(IRQ_O, 32'h1);
        rd(REG_STATUS_OFS, q);
        cmp(q & 32'h4, 32'h4);
        cmp(q & 32'h8, 32'h0);
        LOCK_LOST_I <= 1'b0;
        cyc(6);
        cmp(ALARM_OE_N_O, 32'h1);
        cmp(alarm_wire, 32'h1);
        rd(REG_STATUS_OFS, q);
        cmp(q & 32'h8, 32'h8);
        wr(REG_MASK_OFS, 32'h0);
        HW_FAULT_I <= 1'b1;
        cyc(6);
        cmp(ALARM_OE_N_O, 32'h0);
        cmp(IRQ_O, 32'h0);
        HW_FAULT_I <= 1'b0;
        $display("t_alarm done");
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge CLK_I);
        RST_N_I <= 1'b1;
        t_reset;
        t_rise;
        t_gate(SEL_PPM);
        t_gate(SEL_EVEN);
        t_fall;
        t_rate;
        t_synthesized_rate_sel;
        t_alarm;
        print_verdict;
    end
    // Whole run needs about 22600 cycles
    initial begin
        repeat (40000) @(posedge CLK_I);
        error_cnt++;
        print_verdict;
    end
endmodule // ptp_timing_out_tb_top
